// file: rtl/ubd_pkg.sv
// shared constants and types for the usb buffer descriptor dma block
`default_nettype none
package ubd_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_BASE      = 8'h04;
    localparam logic [7:0]  ADDR_STAT      = 8'h08;
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_HOST_BIT  = 1;
    localparam int          CTRL_LOW_BIT   = 2;
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_NAK_BIT   = 1;
    localparam logic [2:0]  CTRL_RESET     = 3'h0;
    localparam logic [22:0] PAGE_RESET     = 23'h000000;
    // ****************************************
    // descriptor address and field layout
    // ****************************************
    localparam int          TABLE_ALIGN    = 512;
    localparam int          PAGE_LSB       = 9;
    localparam int          EP_LSB         = 5;
    localparam int          TX_BIT         = 4;
    localparam int          ODD_BIT        = 3;
    localparam int          ENTRY_BYTES    = 8;
    localparam logic [31:0] WORD_STEP      = 32'h00000004;
    localparam int          OWN_BIT        = 7;
    localparam int          DATA1_BIT      = 6;
    localparam int          KEEP_BIT       = 5;
    localparam int          PID_LSB        = 2;
    localparam int          BC_LSB         = 16;
    localparam int          BC_W           = 10;
    localparam int          NUM_EP         = 16;
    // ****************************************
    // token pids and link speed
    // ****************************************
    localparam logic [3:0]  PID_OUT        = 4'h1;
    localparam logic [3:0]  PID_IN         = 4'h9;
    localparam logic [3:0]  PID_SETUP      = 4'hD;
    localparam int          FULL_KBPS      = 12000;
    localparam int          LOW_KBPS       = 1500;
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [3:0] pid;
        logic [3:0] ep;
    } ubd_token_t;
    typedef struct packed {
        logic [31:0]     addr;
        logic [BC_W-1:0] len;
        logic            tx;
        logic            data1;
    } ubd_grant_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RDCTL,
        ST_RDADR,
        ST_XFER,
        ST_WRBK
    } ubd_state_t;
endpackage
`default_nettype wire

// file: rtl/ubd_odd_track.sv
// ping-pong even/odd selector per endpoint direction
`default_nettype none
module ubd_odd_track
    import ubd_pkg::*;
#(
    parameter int NUM_EP_P = NUM_EP
) (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    // control
    input  wire logic                          clrAll,
    input  wire logic                          tgEn,
    input  wire logic [$clog2(NUM_EP_P*2)-1:0] tgIdx,
    // state
    output logic      [NUM_EP_P*2-1:0]         oddBits
);
    logic [NUM_EP_P*2-1:0] odd_reg;
    logic [NUM_EP_P*2-1:0] odd_next;
    logic [NUM_EP_P*2-1:0] tgMask;

    always_comb begin
        tgMask = '0;
        tgMask[tgIdx] = tgEn;
        odd_next = clrAll ? '0 : (odd_reg ^ tgMask);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            odd_reg <= '0;
        end else begin
            odd_reg <= odd_next;
        end
    end

    assign oddBits = odd_reg;

    a_odd_flip: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tgEn && !clrAll |=> (odd_reg ^ $past(odd_reg)) == $past(tgMask))
        else $error("odd selector did not toggle exactly one entry");
endmodule
`default_nettype wire

// file: rtl/ubd_dma.sv
// buffer descriptor fetch, grant and write-back engine with apb registers
`default_nettype none
module ubd_dma
    import ubd_pkg::*;
#(
    parameter int NUM_EP_P = NUM_EP
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // system memory master
    output logic                   memReq,
    output logic                   memWe,
    output logic [31:0]            memAddr,
    output logic [31:0]            memWdata,
    input  wire logic              memAck,
    input  wire logic [31:0]       memRdata,
    // serial engine side
    input  wire logic              tokValid,
    input  wire ubd_token_t        tokIn,
    output logic                   tokBusy,
    output logic                   xferStart,
    output logic                   xferNak,
    output ubd_grant_t             xferGrant,
    input  wire logic              xferDone,
    input  wire logic [BC_W-1:0]   xferCount,
    // link configuration
    output logic                   hostMode,
    output logic                   lowSpeed
);
    // ****************************************
    // state
    // ****************************************
    localparam int IDX_W = $clog2(NUM_EP_P*2);
    ubd_state_t     state_reg,  state_next;
    logic [2:0]     ctrl_reg,   ctrl_next;
    logic [22:0]    page_reg,   page_next;
    logic           nak_reg,    nak_next;
    logic           rdy_reg,    rdy_next;
    logic [31:0]    rdat_reg,   rdat_next;
    logic           err_reg,    err_next;
    logic           req_reg,    req_next;
    logic           we_reg,     we_next;
    logic [31:0]    maddr_reg,  maddr_next;
    logic [31:0]    wdat_reg,   wdat_next;
    logic [31:0]    desc_reg,   desc_next;
    logic [31:0]    ctl_reg,    ctl_next;
    logic [3:0]     pid_reg,    pid_next;
    logic [IDX_W-1:0] idx_reg,  idx_next;
    logic           start_reg,  start_next;
    logic           nakp_reg,   nakp_next;
    ubd_grant_t     grant_reg,  grant_next;
    logic           busy_reg,   busy_next;
    logic [NUM_EP_P*2-1:0] oddBits;
    logic           apbWrite;
    logic           apbLive;
    logic           tokAccept;
    logic           tokTx;
    logic           tokOk;
    logic           oddToggle;
    logic           oddClear;
    // ****************************************
    // helpers
    // ****************************************
    // direction from the controller's own viewpoint: 1 = transmit
    function automatic logic pidIsTx(input logic host, input logic [3:0] pid);
        if (host) begin
            pidIsTx = (pid != PID_IN);
        end else begin
            pidIsTx = (pid == PID_IN);
        end
    endfunction
    // entry address inside the table
    function automatic logic [31:0] entryAddr(input logic [22:0] page,
                                              input logic [3:0] ep,
                                              input logic tx,
                                              input logic odd);
        entryAddr = {page, ep, tx, odd, 3'h0};
    endfunction
    // ****************************************
    // apb registers
    // ****************************************
    assign apbLive  = psel && penable;
    assign apbWrite = apbLive && rdy_reg && pwrite;
    always_comb begin
        ctrl_next = ctrl_reg;
        page_next = page_reg;
        nak_next  = nak_reg;
        rdy_next  = apbLive && !rdy_reg;
        rdat_next = rdat_reg;
        err_next  = err_reg;
        // one wait state: answer registered on the second access cycle
        if (apbLive && !rdy_reg) begin
            rdat_next = 32'h00000000;
            err_next  = 1'b0;
            unique case (paddr)
                ADDR_CTRL: rdat_next[2:0] = ctrl_reg;
                ADDR_BASE: rdat_next[31:PAGE_LSB] = page_reg;
                ADDR_STAT: begin
                    rdat_next[STAT_BUSY_BIT] = (state_reg != ST_IDLE);
                    rdat_next[STAT_NAK_BIT]  = nak_reg;
                end
                default:   err_next = 1'b1;
            endcase
        end
        if (apbWrite) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    ctrl_next[CTRL_EN_BIT]  = pwdata[CTRL_EN_BIT];
                    ctrl_next[CTRL_LOW_BIT] = pwdata[CTRL_LOW_BIT];
                    // role swaps only while idle, also in the cycle a token is accepted, whose descriptor still takes its direction from the old role
                    if (state_reg == ST_IDLE) begin
                        ctrl_next[CTRL_HOST_BIT] = pwdata[CTRL_HOST_BIT];
                    end
                end
                ADDR_BASE: page_next = pwdata[31:PAGE_LSB];
                ADDR_STAT: begin
                    if (pwdata[STAT_NAK_BIT]) begin
                        nak_next = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // a refusal in the same cycle as the clear still shows
        if (nakp_next) begin
            nak_next = 1'b1;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
            page_reg <= PAGE_RESET;
            nak_reg  <= 1'b0;
            rdy_reg  <= 1'b0;
            rdat_reg <= 32'h00000000;
            err_reg  <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            page_reg <= page_next;
            nak_reg  <= nak_next;
            rdy_reg  <= rdy_next;
            rdat_reg <= rdat_next;
            err_reg  <= err_next;
        end
    end
    // ****************************************
    // descriptor engine
    // ****************************************
    assign tokOk     = (tokIn.pid == PID_IN) || (tokIn.pid == PID_OUT) ||
                       (tokIn.pid == PID_SETUP);
    assign tokTx     = pidIsTx(ctrl_reg[CTRL_HOST_BIT], tokIn.pid);
    assign tokAccept = (state_reg == ST_IDLE) && tokValid && tokOk &&
                       ctrl_reg[CTRL_EN_BIT];
    assign oddClear  = apbWrite && (paddr == ADDR_CTRL) && !pwdata[CTRL_EN_BIT];
    always_comb begin
        state_next = state_reg;
        req_next   = req_reg;
        we_next    = we_reg;
        maddr_next = maddr_reg;
        wdat_next  = wdat_reg;
        desc_next  = desc_reg;
        ctl_next   = ctl_reg;
        pid_next   = pid_reg;
        idx_next   = idx_reg;
        start_next = 1'b0;
        nakp_next  = 1'b0;
        grant_next = grant_reg;
        oddToggle  = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (tokAccept) begin
                    idx_next   = {tokIn.ep, tokTx};
                    pid_next   = tokIn.pid;
                    // pick the half of the pair that is due next
                    desc_next  = entryAddr(page_reg, tokIn.ep, tokTx,
                                           oddBits[{tokIn.ep, tokTx}]);
                    maddr_next = desc_next;
                    req_next   = 1'b1;
                    we_next    = 1'b0;
                    state_next = ST_RDCTL;
                end
            end
            ST_RDCTL: begin
                if (memAck) begin
                    ctl_next = memRdata;
                    if (!memRdata[OWN_BIT]) begin
                        // processor owns it: refuse, read nothing more
                        req_next   = 1'b0;
                        nakp_next  = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        maddr_next = desc_reg + WORD_STEP;
                        state_next = ST_RDADR;
                    end
                end
            end
            ST_RDADR: begin
                if (memAck) begin
                    req_next        = 1'b0;
                    grant_next.addr = memRdata;
                    grant_next.len  = ctl_reg[BC_LSB +: BC_W];
                    grant_next.tx   = idx_reg[0];
                    grant_next.data1 = ctl_reg[DATA1_BIT];
                    start_next      = 1'b1;
                    state_next      = ST_XFER;
                end
            end
            ST_XFER: begin
                if (xferDone) begin
                    // receive reports what arrived, transmit keeps its length
                    maddr_next = desc_reg;
                    we_next    = 1'b1;
                    req_next   = 1'b1;
                    wdat_next  = 32'h00000000;
                    wdat_next[BC_LSB +: BC_W] = grant_reg.tx ? grant_reg.len : xferCount;
                    wdat_next[DATA1_BIT] = ctl_reg[DATA1_BIT];
                    if (ctl_reg[KEEP_BIT]) begin
                        wdat_next[OWN_BIT]        = 1'b1;
                        wdat_next[PID_LSB +: 4]   = ctl_reg[PID_LSB +: 4];
                    end else begin
                        wdat_next[OWN_BIT]        = 1'b0;
                        wdat_next[PID_LSB +: 4]   = pid_reg;
                    end
                    state_next = ST_WRBK;
                end
            end
            ST_WRBK: begin
                if (memAck) begin
                    req_next   = 1'b0;
                    we_next    = 1'b0;
                    oddToggle  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
        endcase
        // registered so the busy output comes straight from a flop
        busy_next = (state_next != ST_IDLE);
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            req_reg   <= 1'b0;
            we_reg    <= 1'b0;
            maddr_reg <= 32'h00000000;
            wdat_reg  <= 32'h00000000;
            desc_reg  <= 32'h00000000;
            ctl_reg   <= 32'h00000000;
            pid_reg   <= 4'h0;
            idx_reg   <= '0;
            start_reg <= 1'b0;
            nakp_reg  <= 1'b0;
            grant_reg <= '0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_reg   <= req_next;
            we_reg    <= we_next;
            maddr_reg <= maddr_next;
            wdat_reg  <= wdat_next;
            desc_reg  <= desc_next;
            ctl_reg   <= ctl_next;
            pid_reg   <= pid_next;
            idx_reg   <= idx_next;
            start_reg <= start_next;
            nakp_reg  <= nakp_next;
            grant_reg <= grant_next;
            busy_reg  <= busy_next;
        end
    end
    ubd_odd_track #(.NUM_EP_P(NUM_EP_P)) ubd_odd_track_inst (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .clrAll   (oddClear),
        .tgEn     (oddToggle),
        .tgIdx    (idx_reg),
        .oddBits  (oddBits)
    );
    // ****************************************
    // outputs
    // ****************************************
    assign pready    = rdy_reg;
    assign prdata    = rdat_reg;
    assign pslverr   = err_reg;
    assign memReq    = req_reg;
    assign memWe     = we_reg;
    assign memAddr   = maddr_reg;
    assign memWdata  = wdat_reg;
    assign tokBusy   = busy_reg;
    assign xferStart = start_reg;
    assign xferNak   = nakp_reg;
    assign xferGrant = grant_reg;
    assign hostMode  = ctrl_reg[CTRL_HOST_BIT];
    assign lowSpeed  = ctrl_reg[CTRL_LOW_BIT];

    // ****************************************
    // assertions
    // ****************************************
    a_grant_owned: assert property (@(posedge clk_sys) disable iff (!rst_n)
        xferStart |-> ctl_reg[OWN_BIT] && (state_reg == ST_XFER))
        else $error("grant issued for a descriptor the controller does not own");
    a_nak_owner: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RDCTL) && memAck && !memRdata[OWN_BIT]
        |=> xferNak && !xferStart && !memReq)
        else $error("processor-owned descriptor was not refused");
    a_entry_align: assert property (@(posedge clk_sys) disable iff (!rst_n)
        memReq && (state_reg != ST_RDADR) |-> memAddr[2:0] == 3'h0 &&
        memAddr[31:PAGE_LSB] == page_reg)
        else $error("descriptor address not inside the table page");
    a_ptr_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RDADR) && memAck |=> xferGrant.addr == $past(memRdata))
        else $error("buffer pointer not taken from descriptor");
    a_dir_device: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tokAccept && !hostMode |=> idx_reg[0] == ($past(tokIn.pid) == PID_IN))
        else $error("device role direction wrong");
    a_dir_host: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tokAccept && hostMode |=> idx_reg[0] == ($past(tokIn.pid) != PID_IN))
        else $error("host role direction wrong");
    a_own_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_WRBK) && memReq |-> memWe && memWdata[OWN_BIT] == ctl_reg[KEEP_BIT])
        else $error("ownership write-back ignores keep option");
    a_role_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tokBusy && $past(tokBusy) |-> $stable(hostMode))
        else $error("role changed during a descriptor");
    a_mem_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
        else $error("memory request dropped before acknowledge");
    a_apb_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not after one wait state");

    c_grant:    cover property (@(posedge clk_sys) disable iff (!rst_n) xferStart);
    c_nak:      cover property (@(posedge clk_sys) disable iff (!rst_n) xferNak);
    c_host_tx:  cover property (@(posedge clk_sys) disable iff (!rst_n)
        xferStart && hostMode && xferGrant.tx);
    c_keep:     cover property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_WRBK) && memAck && memWdata[OWN_BIT]);
endmodule
`default_nettype wire

// file: test/ubd_mem_model.sv
// system memory model that answers the descriptor engine
`default_nettype none
module ubd_mem_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // memory slave
    input  wire logic        memReq,
    input  wire logic        memWe,
    input  wire logic [31:0] memAddr,
    input  wire logic [31:0] memWdata,
    output logic             memAck,
    output logic [31:0]      memRdata,
    // answer delay in cycles
    input  wire logic [1:0]  slow
);
    timeunit 1ns;
    timeprecision 1ns;
    // one 512-byte page; bits 9 and up are not decoded
    logic [31:0] mem [0:127];
    logic [1:0]  waitCnt;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            memAck <= 1'h0;
            waitCnt <= 2'h0;
            memRdata <= 32'h0;
        end else begin
            memAck <= 1'h0;
            // data toggles between answers so a stale read never matches
            memRdata <= ~memRdata;
            if (memReq && !memAck && waitCnt == slow) begin
                memAck <= 1'h1;
                waitCnt <= 2'h0;
                memRdata <= mem[memAddr[8:2]];
                if (memWe) mem[memAddr[8:2]] <= memWdata;
            end else if (memReq && !memAck) begin
                waitCnt <= waitCnt + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/test_ubd_dma.sv
// self-checking bench for the descriptor dma engine
`default_nettype none
module test_ubd_dma import ubd_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic            clk_sys = 1'h0, rst_n = 1'h0;
    logic            psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic            tokValid = 1'h0, xferDone = 1'h0, errSeen;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0, rd;
    ubd_token_t      tokIn = '0;
    logic [BC_W-1:0] xferCount = '0;
    logic [1:0]      slow = 2'h0;
    logic            pready, pslverr, memReq, memWe, memAck, tokBusy;
    logic            xferStart, xferNak, hostMode, lowSpeed, hostExp;
    logic [31:0]     prdata, memAddr, memWdata, memRdata;
    ubd_grant_t      xferGrant;
    int              miscompares = 0, compares = 0, seed = 35;
    logic [44:0]     notes [$];
    logic            oddExp [32];
    logic [3:0]      pids [3] = '{PID_OUT, PID_IN, PID_SETUP};
    ubd_dma ubd_dma_inst (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .memReq, .memWe, .memAddr, .memWdata, .memAck,
        .memRdata, .tokValid, .tokIn, .tokBusy, .xferStart, .xferNak, .xferGrant,
        .xferDone, .xferCount, .hostMode, .lowSpeed);
    ubd_mem_model ubd_mem_model_inst (.clk_sys, .rst_n, .memReq, .memWe, .memAddr,
        .memWdata, .memAck, .memRdata, .slow);
    always #5 clk_sys = ~clk_sys;
    // ****************************************
    // compares and bus tasks
    // ****************************************
    task automatic chkWord(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chkNote(input logic [44:0] e, input logic [44:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] grant expected %h seen %h", e, g);
        end
    endtask
    task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= we;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'h1;
        // no fixed wait: only the watchdog ends a hung transfer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // one token against a freshly built descriptor, then its write-back, or for a refused token a check that the entry is untouched
    task automatic runTok(input logic [3:0] pid, input logic own, input logic keep);
        logic [3:0]  ep;
        logic        tx, d1, odd;
        logic [9:0]  bc, cnt;
        logic [31:0] a, ptr, ctl;
        int          n;
        ep = $random(seed);
        tx = hostExp ? (pid != PID_IN) : (pid == PID_IN);
        odd = oddExp[{ep, tx}];
        a = {23'h000001, ep, tx, odd, 3'h0};
        bc = $random(seed);
        cnt = $random(seed);
        ptr = $random(seed);
        d1 = $random(seed);
        ctl = {6'h00, bc, 8'h00, own, d1, keep, 5'h00};
        // descriptors are only rewritten while the engine is idle
        ubd_mem_model_inst.mem[a[8:2]] = ctl;
        ubd_mem_model_inst.mem[a[8:2] + 7'h1] = ptr;
        notes.push_back(own ? {1'h0, ptr, bc, tx, d1} : {1'h1, 44'h0});
        slow <= $random(seed);
        xferCount <= cnt;
        tokIn <= {pid, ep};
        tokValid <= 1'h1;
        @(posedge clk_sys);
        tokValid <= 1'h0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (tokBusy !== 1'h0 && n < 40);
        if (n >= 40) miscompares++;
        if (own) begin
            chkWord("write-back", {6'h00, tx ? bc : cnt, 8'h00, keep, d1, keep ? 4'h8 : pid,
                2'h0}, ubd_mem_model_inst.mem[a[8:2]]);
            oddExp[{ep, tx}] = ~odd;
        end else begin
            chkWord("untouched", ctl, ubd_mem_model_inst.mem[a[8:2]]);
        end
    endtask
    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ****************************************
    // serial engine stand-in and grant watcher
    // ****************************************
    always @(posedge clk_sys) begin
        xferDone <= (xferStart === 1'h1);
        if (xferStart === 1'h1 || xferNak === 1'h1) begin
            if (notes.size() == 0) chkNote(45'h0, {1'h1, xferGrant});
            else chkNote(notes.pop_front(), xferNak ? {1'h1, 44'h0} : {1'h0, xferGrant});
        end
    end
    initial begin
        #200000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'h1;
        apb(1'h0, ADDR_CTRL, 32'h0);
        chkWord("ctrl reset", 32'h0, rd);
        apb(1'h0, 8'h0C, 32'h0);
        chkWord("unmapped error", 32'h1, {31'h0, errSeen});
        apb(1'h1, ADDR_BASE, 32'h000003FF);
        apb(1'h0, ADDR_BASE, 32'h0);
        chkWord("table page", 32'h00000200, rd);
        // same descriptors serve both roles; disabling first clears the odd selectors
        for (int r = 0; r < 2; r++) begin
            hostExp = r;
            apb(1'h1, ADDR_CTRL, 32'h0);
            oddExp = '{default: 1'h0};
            apb(1'h1, ADDR_CTRL, {29'h0, hostExp, hostExp, 1'h1});
            // the write lands at the answering edge; look one cycle later
            @(posedge clk_sys);
            chkWord("role and speed", {30'h0, hostExp, hostExp}, {30'h0, lowSpeed, hostMode});
            for (int i = 0; i < 30; i++) runTok(pids[i % 3], (i % 5) != 4, (i % 7) == 6);
            $display("role test %0d done", r);
        end
        apb(1'h0, ADDR_STAT, 32'h0);
        chkWord("refused flag", 32'h2, rd);
        apb(1'h1, ADDR_STAT, 32'h2);
        apb(1'h0, ADDR_STAT, 32'h0);
        chkWord("flag cleared", 32'h0, rd);
        $display("status test done");
        summarize();
    end
endmodule
`default_nettype wire
